// ---- verilog/ecit_pkg.sv ----
// package: register map, field positions, reset values and timing for the capture/interval timer
package ecit_pkg;
  // register indices, not byte offsets (byte address = 4*index)
  localparam logic [7:0] IDX_A_RISE    = 8'h22;
  localparam logic [7:0] IDX_B_RISE    = 8'h23;
  localparam logic [7:0] IDX_A_FALL    = 8'h24;
  localparam logic [7:0] IDX_B_FALL    = 8'h25;
  localparam logic [7:0] IDX_IVL_LO    = 8'h26;
  localparam logic [7:0] IDX_IVL_HI    = 8'h27;
  localparam logic [7:0] IDX_RLD_LO    = 8'h28;
  localparam logic [7:0] IDX_RLD_HI    = 8'h29;
  localparam logic [7:0] IDX_CFG       = 8'h2A;
  localparam logic [7:0] IDX_IRQ_EN    = 8'h2B;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h2C;
  localparam int         ADDR_W        = 10;
  // capture_config fields
  localparam int         CFG_KEEP_FIRST = 7;
  localparam int         CFG_PRESC_LSB  = 4;
  localparam int         CFG_CASCADE    = 3;
  localparam logic [7:0] CFG_WMASK      = 8'hF8;
  // flag / enable bit positions
  localparam int         BIT_A_RISE = 0;
  localparam int         BIT_A_FALL = 1;
  localparam int         BIT_B_RISE = 2;
  localparam int         BIT_B_FALL = 3;
  localparam logic [7:0] NIB_MASK   = 8'h0F;
  // reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [11:0] RST_IVL   = 12'h000;
  localparam logic [15:0] RST_FRC   = 16'h0000;
  // capture counter clock enable divider: 50 MHz to 5 MHz, divided evenly by 10,
  // so the capture counter advances every CNT_DIV cycles
  localparam int          CLK_MHZ   = 50;
  localparam int          TICK_MHZ  = 5;
  localparam logic [3:0]  CNT_DIV   = 4'((CLK_MHZ + TICK_MHZ - 1) / TICK_MHZ);

  // edge event bundle from the synchronisers
  typedef struct packed {
    logic b_fall;
    logic b_rise;
    logic a_fall;
    logic a_rise;
  } ecit_edges_t;

  // apb request bundle
  typedef struct packed {
    logic              sel;
    logic              en;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } ecit_apb_req_t;
endpackage

// ---- verilog/ecit_top.sv ----
// edge capture and interval timer with apb register access
// Summary of operation
// - channel a falling edge loads a fall time: prescaled slice, or low byte cascaded
// - channel b falls on its own input; cascaded it takes upper byte at a fall
// - interval count is 12-bit read-only; low-byte read latches upper nibble
// - high register returns latched nibble in bits 3:0, zero above
// - two 8-bit channels, each with separate rise and fall time registers
// - each of four captures can raise an interrupt when loaded, per enable; channel b captures not while cascaded
// - keep-first clear: every capture overwritten by each newest edge
// - keep-first set: capture holds first edge, ignores later until read
// - prescale code n stores counter bits n+7 down to n
// - cascade bit makes channel b the upper bytes of channel a
// - irq enable bits 3..0 gate b fall, b rise, a fall, a rise
// - status bits 3..0 set on b fall, b rise, a fall, a rise
// - writing one clears a status bit; clear needed before next interrupt
// - all capture, interval, reload and config registers reset to zero
// - 16-bit free-running counter on its own tick, sampled by all captures
// - channel a rising edge loads rise time: prescaled slice, or low byte cascaded
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module ecit_top (
  input  wire  logic        clk,            // 50 MHz system clock
  input  wire  logic        nrst,           // synchronous reset, active low
  input  wire  logic        psel,           // apb select
  input  wire  logic        penable,        // apb access phase
  input  wire  logic        pwrite,         // apb write
  input  wire  logic [11:0] paddr,          // apb byte address
  input  wire  logic [31:0] pwdata,         // apb write data
  output logic        [31:0] prdata,        // apb read data
  output logic               pready,        // apb ready
  output logic               pslverr,       // apb error, unmapped address
  input  wire  logic        edge_input_a,   // capture pin a, asynchronous
  input  wire  logic        edge_input_b,   // capture pin b, asynchronous
  output logic        [3:0]  capture_irq,   // per-source capture requests
  output logic               interval_irq   // interval reload pulse
);

  // index decode used by read and write paths
  function automatic logic is_reg(input logic [11:0] a, input logic [7:0] idx);
    return (a[1:0] == 2'b00) && (a[11:2] == {2'b00, idx});
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return (a[1:0] == 2'b00) && (a[11:2] >= {2'b00, ecit_pkg::IDX_A_RISE})
           && (a[11:2] <= {2'b00, ecit_pkg::IDX_IRQ_FLAGS});
  endfunction

  logic [2:0]  sync_a_q;
  logic [2:0]  sync_b_q;
  logic        lvl_a_q;
  logic        lvl_b_q;
  ecit_pkg::ecit_edges_t ev;
  logic [3:0]  div_q;
  logic        tick;
  logic [15:0] frc_q;
  logic [11:0] ivl_q;
  logic [3:0]  ivl_hold_q;
  logic [7:0]  rld_lo_q;
  logic [3:0]  rld_hi_q;
  logic [7:0]  cfg_q;
  logic [3:0]  irq_en_q;
  logic [3:0]  flags_q;
  logic [7:0]  cap_q [4];
  logic [3:0]  held_q;
  logic [7:0]  slice;
  logic        cascade;
  logic        access;
  logic        wr_acc;
  logic        rd_acc;
  logic [3:0]  cap_rd;
  logic [3:0]  ld;
  logic [7:0]  rd_byte;
  logic [3:0]  clr_mask;

  // three-stage synchroniser, pin a; change accepted when stages two and three agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_a_q <= 3'h0;
    end else begin
      sync_a_q <= {sync_a_q[1:0], edge_input_a};
    end
  end

  // three-stage synchroniser, pin b
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_b_q <= 3'h0;
    end else begin
      sync_b_q <= {sync_b_q[1:0], edge_input_b};
    end
  end

  // filtered level of pin a, edge taken once per accepted change
  // level resets low like the idle pin, so no false edge follows reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lvl_a_q <= 1'b0;
    end else if (sync_a_q[1] == sync_a_q[2]) begin
      lvl_a_q <= sync_a_q[2];
    end
  end

  // filtered level of pin b, tracked in cascade too so no stale edge later
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lvl_b_q <= 1'b0;
    end else if (sync_b_q[1] == sync_b_q[2]) begin
      lvl_b_q <= sync_b_q[2];
    end
  end

  // edge events; channel b disabled when cascaded
  always_comb begin
    ev.a_rise = (sync_a_q[1] == sync_a_q[2]) && sync_a_q[2] && !lvl_a_q;
    ev.a_fall = (sync_a_q[1] == sync_a_q[2]) && !sync_a_q[2] && lvl_a_q;
    ev.b_rise = (sync_b_q[1] == sync_b_q[2]) && sync_b_q[2] && !lvl_b_q
                && !cascade;
    ev.b_fall = (sync_b_q[1] == sync_b_q[2]) && !sync_b_q[2] && lvl_b_q
                && !cascade;
  end

  // counter tick divider
  // one-cycle enable pulse; the counters never see a second clock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_q <= 4'h0;
    end else if (div_q == ecit_pkg::CNT_DIV - 4'h1) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  assign tick = (div_q == ecit_pkg::CNT_DIV - 4'h1);

  // free-running capture counter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      frc_q <= ecit_pkg::RST_FRC;
    end else if (tick) begin
      frc_q <= frc_q + 16'h0001;
    end
  end

  assign cascade = cfg_q[ecit_pkg::CFG_CASCADE];
  // prescaled window of the counter
  assign slice   = 8'(frc_q >> cfg_q[ecit_pkg::CFG_PRESC_LSB +: 3]);

  // apb decode; side effects only at the completing edge
  // read side effects (nibble latch, hold release) must act once per transfer
  assign access = psel && penable && pready;
  assign wr_acc = access && pwrite;
  assign rd_acc = access && !pwrite;

  // register reads that release keep-first holds
  always_comb begin
    cap_rd[0] = rd_acc && is_reg(paddr, ecit_pkg::IDX_A_RISE);
    cap_rd[1] = rd_acc && is_reg(paddr, ecit_pkg::IDX_A_FALL);
    cap_rd[2] = rd_acc && is_reg(paddr, ecit_pkg::IDX_B_RISE);
    cap_rd[3] = rd_acc && is_reg(paddr, ecit_pkg::IDX_B_FALL);
  end

  // load strobes: cap index 0 a rise, 1 a fall, 2 b rise, 3 b fall
  // keep-first hold is released only by a read of the same register
  always_comb begin
    ld[0] = ev.a_rise && !(cfg_q[ecit_pkg::CFG_KEEP_FIRST] && held_q[0]);
    ld[1] = ev.a_fall && !(cfg_q[ecit_pkg::CFG_KEEP_FIRST] && held_q[1]);
    ld[2] = (cascade ? ev.a_rise : ev.b_rise)
            && !(cfg_q[ecit_pkg::CFG_KEEP_FIRST] && held_q[2]);
    ld[3] = (cascade ? ev.a_fall : ev.b_fall)
            && !(cfg_q[ecit_pkg::CFG_KEEP_FIRST] && held_q[3]);
  end

  // capture registers, apb writes allowed, loads win
  generate
    for (genvar i = 0; i < 4; i++) begin : g_cap
      always_ff @(posedge clk) begin
        if (!nrst) begin
          cap_q[i]  <= ecit_pkg::RST_BYTE;
          held_q[i] <= 1'b0;
        end else begin
          if (ld[i]) begin
            if (i < 2) begin
              cap_q[i] <= cascade ? frc_q[7:0] : slice;
            end else begin
              cap_q[i] <= cascade ? frc_q[15:8] : slice;
            end
          end else if (wr_acc && is_reg(paddr, (i == 0) ? ecit_pkg::IDX_A_RISE :
                                               (i == 1) ? ecit_pkg::IDX_A_FALL :
                                               (i == 2) ? ecit_pkg::IDX_B_RISE :
                                                          ecit_pkg::IDX_B_FALL)) begin
            cap_q[i] <= pwdata[7:0];
          end
          if (ld[i]) begin
            held_q[i] <= 1'b1;
          end else if (cap_rd[i]) begin
            held_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // configuration register, reserved bits kept zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_q <= ecit_pkg::RST_BYTE;
    end else if (wr_acc && is_reg(paddr, ecit_pkg::IDX_CFG)) begin
      cfg_q <= pwdata[7:0] & ecit_pkg::CFG_WMASK;
    end
  end

  // capture request enables
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_en_q <= 4'h0;
    end else if (wr_acc && is_reg(paddr, ecit_pkg::IDX_IRQ_EN)) begin
      irq_en_q <= pwdata[3:0];
    end
  end

  // reload low byte
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rld_lo_q <= ecit_pkg::RST_BYTE;
    end else if (wr_acc && is_reg(paddr, ecit_pkg::IDX_RLD_LO)) begin
      rld_lo_q <= pwdata[7:0];
    end
  end

  // reload upper nibble
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rld_hi_q <= 4'h0;
    end else if (wr_acc && is_reg(paddr, ecit_pkg::IDX_RLD_HI)) begin
      rld_hi_q <= pwdata[3:0];
    end
  end

  // write-one-to-clear mask of the status register
  assign clr_mask = (wr_acc && is_reg(paddr, ecit_pkg::IDX_IRQ_FLAGS)) ? pwdata[3:0]
                                                                       : 4'h0;

  // status flags: event sets, write-one clears, set wins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= (flags_q & ~clr_mask)
                 | {ev.b_fall, ev.b_rise, ev.a_fall, ev.a_rise};
    end
  end

  // capture requests: raised on a load only while the flag was clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      capture_irq <= 4'h0;
    end else begin
      capture_irq[ecit_pkg::BIT_A_RISE] <= ld[0] && irq_en_q[0] && !flags_q[0];
      capture_irq[ecit_pkg::BIT_A_FALL] <= ld[1] && irq_en_q[1] && !flags_q[1];
      capture_irq[ecit_pkg::BIT_B_RISE] <= ld[2] && !cascade && irq_en_q[2]
                                           && !flags_q[2];
      capture_irq[ecit_pkg::BIT_B_FALL] <= ld[3] && !cascade && irq_en_q[3]
                                           && !flags_q[3];
    end
  end

  // interval down counter with reload at zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ivl_q <= ecit_pkg::RST_IVL;
    end else if (tick) begin
      if (ivl_q == 12'h000) begin
        ivl_q <= {rld_hi_q, rld_lo_q};
      end else begin
        ivl_q <= ivl_q - 12'h001;
      end
    end
  end

  // interval request, one cycle at each reload; a zero reload requests every tick
  always_ff @(posedge clk) begin
    if (!nrst) begin
      interval_irq <= 1'b0;
    end else begin
      interval_irq <= tick && (ivl_q == 12'h000);
    end
  end

  // upper nibble latch on low-byte read
  // frozen so a later high read matches the low byte already taken
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ivl_hold_q <= 4'h0;
    end else if (rd_acc && is_reg(paddr, ecit_pkg::IDX_IVL_LO)) begin
      ivl_hold_q <= ivl_q[11:8];
    end
  end

  // read mux
  always_comb begin
    rd_byte = 8'h00;
    if (is_reg(paddr, ecit_pkg::IDX_A_RISE))    rd_byte = cap_q[0];
    if (is_reg(paddr, ecit_pkg::IDX_A_FALL))    rd_byte = cap_q[1];
    if (is_reg(paddr, ecit_pkg::IDX_B_RISE))    rd_byte = cap_q[2];
    if (is_reg(paddr, ecit_pkg::IDX_B_FALL))    rd_byte = cap_q[3];
    if (is_reg(paddr, ecit_pkg::IDX_IVL_LO))    rd_byte = ivl_q[7:0];
    if (is_reg(paddr, ecit_pkg::IDX_IVL_HI))    rd_byte = {4'h0, ivl_hold_q};
    if (is_reg(paddr, ecit_pkg::IDX_RLD_LO))    rd_byte = rld_lo_q;
    if (is_reg(paddr, ecit_pkg::IDX_RLD_HI))    rd_byte = {4'h0, rld_hi_q};
    if (is_reg(paddr, ecit_pkg::IDX_CFG))       rd_byte = cfg_q;
    if (is_reg(paddr, ecit_pkg::IDX_IRQ_EN))    rd_byte = {4'h0, irq_en_q};
    if (is_reg(paddr, ecit_pkg::IDX_IRQ_FLAGS)) rd_byte = {4'h0, flags_q};
  end

  // apb ready: one cycle, the first of the access phase
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // apb error with ready, for unmapped or misaligned addresses
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !mapped(paddr);
    end
  end

  // apb read data, registered at the setup edge, zero outside reads
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

endmodule

// ---- tb/ecit_properties.sv ----
// checker: port-level properties of the capture and interval timer
`timescale 1ns/1ns
module ecit_properties (
  input wire logic        clk,         // clock
  input wire logic        nrst,        // sync reset, active low
  input wire logic        psel,        // apb select
  input wire logic        penable,     // apb access phase
  input wire logic        pwrite,      // apb write
  input wire logic [11:0] paddr,       // apb byte address
  input wire logic [31:0] pwdata,      // apb write data
  input wire logic [31:0] prdata,      // apb read data
  input wire logic        pready,      // apb ready
  input wire logic [3:0]  capture_irq, // capture pulses
  input wire logic        interval_irq // reload pulse
);
  logic       acc;
  logic       cas_q;
  logic [3:0] en_q, arm_q, seen_q, w1c;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // completed transfer and one-to-clear mask
  assign acc = psel && penable && pready;
  assign w1c = (acc && pwrite && paddr == 12'h0b0) ? pwdata[3:0] : 4'h0;
  // shadow of enables, cascade, rearm and raised sources
  always_ff @(posedge clk) begin
    if (!nrst) begin
      en_q   <= 4'h0;
      cas_q  <= 1'b0;
      arm_q  <= 4'hf;
      seen_q <= 4'h0;
    end else begin
      if (acc && pwrite && paddr == 12'h0ac) en_q <= pwdata[3:0];
      if (acc && pwrite && paddr == 12'h0a8) cas_q <= pwdata[3];
      arm_q  <= (arm_q & ~capture_irq) | w1c;
      seen_q <= (seen_q | capture_irq) & ~w1c;
    end
  end
  // request timing, gating and register views
  property p_rst_quiet; nrst && !$past(nrst) |-> !pready && !interval_irq && !capture_irq; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
  property p_irq_gate; (capture_irq & ~(en_q | $past(en_q))) == 4'h0; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request from disabled source");
  property p_irq_rearm; (capture_irq & ~arm_q) == 4'h0; endproperty
  a_irq_rearm: assert property (p_irq_rearm) else $error("request before flag cleared");
  property p_irq_once; |capture_irq |=> (capture_irq & $past(capture_irq)) == 4'h0; endproperty
  a_irq_once: assert property (p_irq_once) else $error("capture request held");
  property p_ivl_pulse; interval_irq |=> !interval_irq [*8]; endproperty
  a_ivl_pulse: assert property (p_ivl_pulse) else $error("interval pulse too close");
  property p_hi_nibble; acc && !pwrite && paddr == 12'h09c |-> prdata[31:4] == 28'h000_0000; endproperty
  a_hi_nibble: assert property (p_hi_nibble) else $error("count high upper bits set");
  property p_flags; acc && !pwrite && paddr == 12'h0b0 |-> (prdata[3:0] & seen_q) == seen_q; endproperty
  a_flags: assert property (p_flags) else $error("raised source missing in flags");
  property p_cascade; cas_q && $past(cas_q, 8) |-> capture_irq[3:2] == 2'b00; endproperty
  a_cascade: assert property (p_cascade) else $error("channel b request in cascade");
  // main scenarios reached
  c_rise: cover property (capture_irq[0]);
  c_ivl: cover property (interval_irq);
  c_casc: cover property (cas_q && capture_irq[1]);
endmodule

// ---- tb/ecit_pins.sv ----
// partner: the two capture pins outside the device
`timescale 1ns/1ns
module ecit_pins (
  input  wire logic clk,          // launch clock
  output logic      edge_input_a, // pin a level
  output logic      edge_input_b  // pin b level
);
  // pins rest low until firmware asks for a level
  initial begin
    edge_input_a = 1'b0;
    edge_input_b = 1'b0;
  end
  // new levels launched just after a clock edge
  task automatic put(input logic a, input logic b);
    @(posedge clk);
    edge_input_a <= a;
    edge_input_b <= b;
  endtask
endmodule

// ---- tb/ecit_top_tb.sv ----
// testbench: firmware over apb, pin partner and checks for the timer block
`timescale 1ns/1ns
module ecit_top_tb;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic        pready, pslverr, rerr, edge_input_a, edge_input_b, interval_irq;
  logic [3:0]  capture_irq;
  logic [7:0]  lfsr = 8'h2e;
  int          n_errors = 0, cmp_count = 0, cyc = 0, t0, t1, e, r;
  int          irq_n [4] = '{0, 0, 0, 0};
  always #10 clk = ~clk;
  // cycles since reset release and capture pulse tallies
  always @(posedge clk) begin
    cyc <= nrst ? cyc + 1 : 0;
    for (int k = 0; k < 4; k++) irq_n[k] <= irq_n[k] + int'(capture_irq[k]);
  end
  ecit_top u_ecit_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .edge_input_a(edge_input_a), .edge_input_b(edge_input_b), .capture_irq(capture_irq),
    .interval_irq(interval_irq));
  ecit_pins u_ecit_pins (.clk(clk), .edge_input_a(edge_input_a), .edge_input_b(edge_input_b));
  // pseudo-random byte and expected counter value at cycle c
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [15:0] est(input int c);
    return 16'(c / int'(ecit_pkg::CNT_DIV));
  endfunction
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    $display("CHECK FAILED wait expected answer seen none");
    report_and_stop();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer held until pready, released after it
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) hang();
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), exp, rdat);
  endtask
  // timed reads may trail the estimate by one tick or lead it by up to two
  task automatic rdn(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    apb(1'b0, idx, 8'h00);
    d = rdat[7:0] - exp + 8'h01;
    cmp_count++;
    if (d > 8'h03 || $isunknown(rdat) || rdat[31:8] !== 24'h00_0000) begin
      n_errors++;
      $display("CHECK FAILED reg %h expected about %h seen %h", idx, exp, rdat);
    end
  endtask
  task automatic pin(input logic a, input logic b);
    u_ecit_pins.put(a, b);
    e = cyc;
    repeat (20) @(posedge clk);
  endtask
  task automatic waitivl(output int t);
    int n;
    for (n = 0; n < 20000; n++) begin
      @(posedge clk);
      if (interval_irq === 1'b1) break;
    end
    t = cyc;
    if (n == 20000) hang();
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    // reset values, reserved bits, read-only count and refused address
    for (int i = 34; i <= 44; i++) rdc(8'(i), 32'h0000_0000);
    apb(1'b0, 8'h2d, 8'h00);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, rerr});
    wr(ecit_pkg::IDX_CFG, 8'hff);
    rdc(ecit_pkg::IDX_CFG, 32'h0000_00f8);
    wr(ecit_pkg::IDX_IRQ_EN, 8'hff);
    rdc(ecit_pkg::IDX_IRQ_EN, 32'h0000_000f);
    wr(ecit_pkg::IDX_RLD_HI, 8'hf0);
    rdc(ecit_pkg::IDX_RLD_HI, 32'h0000_0000);
    wr(ecit_pkg::IDX_IVL_LO, 8'hff);
    rdc(ecit_pkg::IDX_IVL_LO, 32'h0000_0000);
    $display("test registers done");
    // prescale sweep on both channels and all four sources
    for (int n = 0; n < 8; n++) begin
      wr(ecit_pkg::IDX_CFG, {1'b0, 3'(n), 4'h0});
      lfsr = nxt(lfsr);
      repeat (lfsr[5:0]) @(posedge clk);
      pin(1'b1, 1'b1);
      t0 = e;
      pin(1'b0, 1'b0);
      rdn(ecit_pkg::IDX_A_RISE, 8'(est(t0) >> n));
      rdn(ecit_pkg::IDX_B_RISE, 8'(est(t0) >> n));
      rdn(ecit_pkg::IDX_A_FALL, 8'(est(e) >> n));
      rdn(ecit_pkg::IDX_B_FALL, 8'(est(e) >> n));
      rdc(ecit_pkg::IDX_IRQ_FLAGS, 32'h0000_000f);
      wr(ecit_pkg::IDX_IRQ_FLAGS, 8'h0f);
      rdc(ecit_pkg::IDX_IRQ_FLAGS, 32'h0000_0000);
    end
    for (int k = 0; k < 4; k++) chk("requests", 32'h0000_0008, 32'(irq_n[k]));
    $display("test prescale done");
    // keep-first holds the first rise; plain mode keeps the newest
    wr(ecit_pkg::IDX_CFG, 8'h80);
    pin(1'b1, 1'b0);
    t0 = e;
    pin(1'b0, 1'b0);
    repeat (200) @(posedge clk);
    pin(1'b1, 1'b0);
    rdn(ecit_pkg::IDX_A_RISE, 8'(est(t0)));
    chk("a rise requests", 32'h0000_0009, 32'(irq_n[0]));
    wr(ecit_pkg::IDX_IRQ_FLAGS, 8'h0f);
    wr(ecit_pkg::IDX_CFG, 8'h00);
    pin(1'b0, 1'b0);
    repeat (200) @(posedge clk);
    pin(1'b1, 1'b0);
    rdn(ecit_pkg::IDX_A_RISE, 8'(est(e)));
    chk("a rise requests", 32'h0000_000a, 32'(irq_n[0]));
    $display("test keep first done");
    // cascade: channel b holds the upper byte, its own pin ignored
    wr(ecit_pkg::IDX_IRQ_FLAGS, 8'h0f);
    wr(ecit_pkg::IDX_CFG, 8'h08);
    pin(1'b0, 1'b1);
    t0 = e;
    pin(1'b1, 1'b0);
    rdn(ecit_pkg::IDX_A_FALL, 8'(est(t0)));
    rdn(ecit_pkg::IDX_B_FALL, 8'(est(t0) >> 8));
    rdn(ecit_pkg::IDX_A_RISE, 8'(est(e)));
    rdn(ecit_pkg::IDX_B_RISE, 8'(est(e) >> 8));
    rdc(ecit_pkg::IDX_IRQ_FLAGS, 32'h0000_0003);
    wr(ecit_pkg::IDX_CFG, 8'h00);
    $display("test cascade done");
    // interval reload period and coherent high nibble
    lfsr = nxt(lfsr);
    r = {4'h5, lfsr | 8'h20};
    wr(ecit_pkg::IDX_RLD_LO, lfsr | 8'h20);
    wr(ecit_pkg::IDX_RLD_HI, 8'h05);
    repeat (20) @(posedge clk);
    waitivl(t0);
    waitivl(t1);
    chk("interval period", 32'((r + 1) * int'(ecit_pkg::CNT_DIV)), 32'(t1 - t0));
    rdn(ecit_pkg::IDX_IVL_LO, 8'(r - 1));
    repeat (2700) @(posedge clk);
    rdc(ecit_pkg::IDX_IVL_HI, 32'h0000_0005);
    apb(1'b0, ecit_pkg::IDX_IVL_LO, 8'h00);
    rdc(ecit_pkg::IDX_IVL_HI, 32'h0000_0004);
    $display("test interval done");
    report_and_stop();
  end
endmodule
bind ecit_top ecit_properties u_ecit_properties (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .capture_irq(capture_irq), .interval_irq(interval_irq));
